// ---- src/ckcp_map.vh ----
// constant definitions for the clock generator control pin block
`ifndef CKCP_MAP_VH
`define CKCP_MAP_VH
`define CKCP_MODE_I2C        1'b1
`define CKCP_MODE_SPI        1'b0
`define CKCP_STEP_W          16
`define CKCP_STEP_RST        16'h0001
`define CKCP_SEL_OUT_W       4
`define CKCP_SEL_OUT_RST     4'h0
`define CKCP_INPUT_SEL_RST   2'h3
`define CKCP_IRQ_SEL_STATUS  2
// idle word of the pin synchronisers, bit 12 down to bit 0:
// i2c, a1, a0/cs_n, sclk, rst_n, disable, lock, xtal, realign_n, down, up, choice[1:0]
`define CKCP_PIN_IDLE        13'h1F13
`endif

// ---- src/ckcp_pins.v ----
// control and status pin logic of a multi-output clock generator
// Behaviour
// - interface select high means I2C, low means SPI.
// - data pin is two-way in I2C and 3-wire SPI, input in 4-wire.
// - address/output pin is address bit 1 in I2C, read data in 4-wire SPI.
// - all serial transfers are timed from the one serial clock input.
// - shared pin is address bit 0 in I2C, active-low chip select in SPI.
// - interrupt output goes low when any status condition changes.
// - reset input returns step and input settings, interrupt line and output enables to defaults.
// - clock outputs stay disabled while reset is held.
// - output-disable high turns off every clock output.
// - lock status high while locked, low when out of lock.
// - dedicated output flags loss of crystal input signal.
// - realign low resets output dividers to realign outputs.
// - step-down pulse lowers selected output frequency by step size.
// - step-up pulse raises selected output frequency by step size.
// - input choice pins pick active input only in manual pin mode.
`timescale 1ns/1ps
`include "ckcp_map.vh"
module ckcp_pins #(
   parameter NUM_OUT = 10
) (
   input  wire                       REF_CLK_IN,
   input  wire                       NRST_IN,
   input  wire                       I2C_SELECT_IN,
   input  wire                       SPI_FOUR_WIRE_IN,
   input  wire                       SERIAL_CLK_IN,
   input  wire                       SERIAL_DATA_IN,
   output wire                       SERIAL_DATA_OUT,
   output wire                       SERIAL_DATA_OE_OUT,
   input  wire                       CORE_DATA_IN,
   input  wire                       CORE_DATA_DRIVE_IN,
   output wire                       CORE_DATA_OUT,
   input  wire                       ADDR_BIT1_OR_READ_DATA_IN,
   output wire                       ADDR_BIT1_OR_READ_DATA_OUT,
   output wire                       ADDR_BIT1_OR_READ_DATA_OE_OUT,
   input  wire                       ADDR_BIT0_OR_CHIP_SELECT_N_IN,
   output wire                       I2C_MODE_OUT,
   output reg  [1:0]                 I2C_ADDR_LOW_OUT,
   output wire                       CHIP_SELECTED_OUT,
   output reg                        SERIAL_CLK_OUT,
   input  wire                       DEVICE_RESET_N_IN,
   input  wire                       OUTPUT_DISABLE_IN,
   output reg  [NUM_OUT-1:0]         CLK_OUT_ENABLE_OUT,
   input  wire                       PLL_LOCKED_IN,
   input  wire                       CRYSTAL_PRESENT_IN,
   output reg                        PLL_LOCK_STATUS_OUT,
   output reg                        CRYSTAL_SIGNAL_LOSS_N_OUT,
   output reg                        IRQ_OUT_N_OUT,
   input  wire                       IRQ_CLEAR_IN,
   input  wire                       DIVIDER_REALIGN_N_IN,
   input  wire                       SOFT_RESET_IN,
   output reg                        DIVIDER_RESET_OUT,
   input  wire                       FREQ_STEP_DOWN_IN,
   input  wire                       FREQ_STEP_UP_IN,
   input  wire [`CKCP_SEL_OUT_W-1:0] STEP_OUTPUT_SEL_IN,
   input  wire [`CKCP_STEP_W-1:0]    STEP_SIZE_IN,
   output reg                        STEP_VALID_OUT,
   output reg                        STEP_DOWN_OUT,
   output reg  [`CKCP_SEL_OUT_W-1:0] STEP_TARGET_OUT,
   output reg  [`CKCP_STEP_W-1:0]    STEP_AMOUNT_OUT,
   input  wire                       MANUAL_PIN_MODE_IN,
   input  wire                       INPUT_CHOICE_BIT0_IN,
   input  wire                       INPUT_CHOICE_BIT1_IN,
   output reg  [1:0]                 ACTIVE_INPUT_OUT,
   output wire                       DEVICE_RESET_ACTIVE_OUT
);
   // two-flop synchronisers for every pin; pull levels handled at the pad
   // the serial data pin is left out: it is a two-way line handed raw to the core
   localparam NS = 13;
   // bit positions of the pins inside the synchronised word
   localparam P_I2C    = 12;
   localparam P_A1     = 11;
   localparam P_A0_CS  = 10;
   localparam P_SCLK   = 9;
   localparam P_RST_N  = 8;
   localparam P_DIS    = 7;
   localparam P_LOCK   = 6;
   localparam P_XTAL   = 5;
   localparam P_ALIGN  = 4;
   localparam P_DOWN   = 3;
   localparam P_UP     = 2;
   localparam P_CH_HI  = 1;
   localparam P_CH_LO  = 0;
   wire [NS-1:0] pin_raw;
   reg  [NS-1:0] pin_meta;
   reg  [NS-1:0] pin_sync;
   assign pin_raw = {I2C_SELECT_IN, ADDR_BIT1_OR_READ_DATA_IN, ADDR_BIT0_OR_CHIP_SELECT_N_IN,
                     SERIAL_CLK_IN, DEVICE_RESET_N_IN, OUTPUT_DISABLE_IN, PLL_LOCKED_IN,
                     CRYSTAL_PRESENT_IN, DIVIDER_REALIGN_N_IN, FREQ_STEP_DOWN_IN,
                     FREQ_STEP_UP_IN, INPUT_CHOICE_BIT1_IN, INPUT_CHOICE_BIT0_IN};
   // reset values equal pulled idle levels so power-up is quiet;
   // any other value would fake a step edge or a status change as reset lifts
   always @(posedge REF_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         pin_meta <= `CKCP_PIN_IDLE;
         pin_sync <= `CKCP_PIN_IDLE;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end
   // synchronised pin levels, the only copies the logic below may read
   wire s_i2c    = pin_sync[P_I2C];
   wire s_a1     = pin_sync[P_A1];
   wire s_a0_cs  = pin_sync[P_A0_CS];
   wire s_sclk   = pin_sync[P_SCLK];
   wire s_rst_n  = pin_sync[P_RST_N];
   wire s_dis    = pin_sync[P_DIS];
   wire s_lock   = pin_sync[P_LOCK];
   wire s_xtal   = pin_sync[P_XTAL];
   wire s_align  = pin_sync[P_ALIGN];
   wire s_down   = pin_sync[P_DOWN];
   wire s_up     = pin_sync[P_UP];
   wire [1:0] s_choice = pin_sync[P_CH_HI:P_CH_LO];

   // limitation: chip select gates the drivers through its synchronised copy,
   // so a host must allow two reference clocks after select before read data;
   // trading that latency for glitch-free enables on a slow, noisy pin
   // serial pin steering; the data pin is asynchronous two-way, so pass through
   assign I2C_MODE_OUT       = (s_i2c == `CKCP_MODE_I2C);
   wire spi4 = ~I2C_MODE_OUT & SPI_FOUR_WIRE_IN;
   assign CORE_DATA_OUT      = SERIAL_DATA_IN;
   assign SERIAL_DATA_OUT    = I2C_MODE_OUT ? 1'b0 : CORE_DATA_DRIVE_IN & CORE_DATA_IN;
   assign SERIAL_DATA_OE_OUT = ~spi4 & CORE_DATA_DRIVE_IN & (I2C_MODE_OUT | ~s_a0_cs
                               ? (I2C_MODE_OUT ? ~CORE_DATA_IN : 1'b1) : 1'b0);
   assign ADDR_BIT1_OR_READ_DATA_OUT    = CORE_DATA_IN;
   assign ADDR_BIT1_OR_READ_DATA_OE_OUT = spi4 & ~s_a0_cs & CORE_DATA_DRIVE_IN;
   assign CHIP_SELECTED_OUT = ~I2C_MODE_OUT & ~s_a0_cs;
   // reset level exported so the settings logic can reload its defaults
   assign DEVICE_RESET_ACTIVE_OUT = ~s_rst_n;
   wire soft_rst = ~s_rst_n;

   // the serial clock copy lags its pin by three reference clocks,
   // but a serial clock level is seen if it lasts one reference clock or more;
   // address bits are only meaningful in i2c mode, zero otherwise
   // address capture, serial clock and output gating
   always @(posedge REF_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         I2C_ADDR_LOW_OUT   <= 2'h0;
         SERIAL_CLK_OUT     <= 1'b1;
         CLK_OUT_ENABLE_OUT <= {NUM_OUT{1'b0}};
         DIVIDER_RESET_OUT  <= 1'b1;
      end else begin
         SERIAL_CLK_OUT <= s_sclk;
         if (I2C_MODE_OUT)
            I2C_ADDR_LOW_OUT <= {s_a1, s_a0_cs};
         else
            I2C_ADDR_LOW_OUT <= 2'h0;
         // outputs off in reset or when disabled
         CLK_OUT_ENABLE_OUT <= (soft_rst | s_dis) ? {NUM_OUT{1'b0}} : {NUM_OUT{1'b1}};
         // soft reset also clears dividers, giving tighter alignment
         DIVIDER_RESET_OUT <= ~s_align | soft_rst | SOFT_RESET_IN;
      end
   end

   // status outputs and change-driven interrupt; set beats clear
   // previous levels reset to the idle word, so lifting reset raises nothing
   // a device reset beats both and leaves the interrupt line released
   reg prev_lock;
   reg prev_xtal;
   wire changed = (s_lock != prev_lock) | (s_xtal != prev_xtal);
   always @(posedge REF_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         PLL_LOCK_STATUS_OUT       <= 1'b0;
         CRYSTAL_SIGNAL_LOSS_N_OUT <= 1'b0;
         prev_lock                 <= 1'b0;
         prev_xtal                 <= 1'b0;
         IRQ_OUT_N_OUT             <= 1'b1;
      end else begin
         prev_lock <= s_lock;
         prev_xtal <= s_xtal;
         PLL_LOCK_STATUS_OUT       <= s_lock;
         CRYSTAL_SIGNAL_LOSS_N_OUT <= s_xtal;
         if (soft_rst)
            IRQ_OUT_N_OUT <= 1'b1;
         else if (changed)
            IRQ_OUT_N_OUT <= 1'b0;
         else if (IRQ_CLEAR_IN)
            IRQ_OUT_N_OUT <= 1'b1;
      end
   end

   // frequency step on rising edge of either pin; both at once cancel
   // both rising together is taken as no request rather than a guess
   // edges come from the synchronised copies, never from the raw pins
   reg prev_down;
   reg prev_up;
   wire down_edge = s_down & ~prev_down;
   wire up_edge   = s_up & ~prev_up;
   always @(posedge REF_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         prev_down        <= 1'b0;
         prev_up          <= 1'b0;
         STEP_VALID_OUT   <= 1'b0;
         STEP_DOWN_OUT    <= 1'b0;
         STEP_TARGET_OUT  <= `CKCP_SEL_OUT_RST;
         STEP_AMOUNT_OUT  <= `CKCP_STEP_RST;
         ACTIVE_INPUT_OUT <= `CKCP_INPUT_SEL_RST;
      end else begin
         prev_down      <= s_down;
         prev_up        <= s_up;
         STEP_VALID_OUT <= ~soft_rst & (down_edge ^ up_edge);
         // a device reset drops any step and reloads the step defaults
         if (soft_rst) begin
            STEP_DOWN_OUT   <= 1'b0;
            STEP_TARGET_OUT <= `CKCP_SEL_OUT_RST;
            STEP_AMOUNT_OUT <= `CKCP_STEP_RST;
         end else if (down_edge ^ up_edge) begin
            STEP_DOWN_OUT   <= down_edge;
            STEP_TARGET_OUT <= STEP_OUTPUT_SEL_IN;
            STEP_AMOUNT_OUT <= STEP_SIZE_IN;
         end
         if (soft_rst)
            ACTIVE_INPUT_OUT <= `CKCP_INPUT_SEL_RST;
         else if (MANUAL_PIN_MODE_IN)
            ACTIVE_INPUT_OUT <= s_choice;
      end
   end
endmodule // ckcp_pins

// ---- tb/ckcp_properties.sv ----
// assertion checker for the clock generator control pins
`timescale 1ns/1ps
module ckcp_properties #(parameter NUM_OUT = 10) (
   input wire               REF_CLK_IN,
   input wire               NRST_IN,
   input wire               OUTPUT_DISABLE_IN,
   input wire               DEVICE_RESET_N_IN,
   input wire [NUM_OUT-1:0] CLK_OUT_ENABLE_OUT,
   input wire               PLL_LOCKED_IN,
   input wire               PLL_LOCK_STATUS_OUT,
   input wire               IRQ_OUT_N_OUT,
   input wire               I2C_MODE_OUT,
   input wire               CORE_DATA_IN,
   input wire               CORE_DATA_DRIVE_IN,
   input wire               SERIAL_DATA_OE_OUT,
   input wire               ADDR_BIT1_OR_READ_DATA_OE_OUT,
   input wire               FREQ_STEP_UP_IN,
   input wire               FREQ_STEP_DOWN_IN,
   input wire               STEP_VALID_OUT,
   input wire               STEP_DOWN_OUT
);
   reg  [2:0] age;
   wire       up = (age == 3'h5);
   // sync path refills after reset, so $past looks are gated until then
   always @(posedge REF_CLK_IN or negedge NRST_IN)
      if (!NRST_IN) age <= 3'h0; else if (!up) age <= age + 3'h1;
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!NRST_IN);
   chk_outputs_off: assert property (up && $past(OUTPUT_DISABLE_IN, 3) &&
      $past(OUTPUT_DISABLE_IN, 4) |-> ~|CLK_OUT_ENABLE_OUT) else $error("outputs on");
   chk_outputs_on: assert property (up && !$past(OUTPUT_DISABLE_IN, 3) &&
      !$past(OUTPUT_DISABLE_IN, 4) && $past(DEVICE_RESET_N_IN, 3) &&
      $past(DEVICE_RESET_N_IN, 4) |-> &CLK_OUT_ENABLE_OUT) else $error("outputs off");
   chk_reset_off: assert property (up && !$past(DEVICE_RESET_N_IN, 3) &&
      !$past(DEVICE_RESET_N_IN, 4) |-> ~|CLK_OUT_ENABLE_OUT) else $error("on in reset");
   chk_lock_copy: assert property (up && $past(PLL_LOCKED_IN, 3) ==
      $past(PLL_LOCKED_IN, 4) |-> PLL_LOCK_STATUS_OUT == $past(PLL_LOCKED_IN, 3))
      else $error("lock status wrong");
   chk_irq_change: assert property (up && $past(DEVICE_RESET_N_IN, 3) &&
      $past(PLL_LOCKED_IN, 3) != $past(PLL_LOCKED_IN, 4) |-> ##[0:1] !IRQ_OUT_N_OUT)
      else $error("no irq on change");
   chk_i2c_drive: assert property (I2C_MODE_OUT |-> !ADDR_BIT1_OR_READ_DATA_OE_OUT &&
      SERIAL_DATA_OE_OUT == (CORE_DATA_DRIVE_IN & ~CORE_DATA_IN)) else $error("i2c drive");
   chk_step_up: assert property (up && DEVICE_RESET_N_IN && $rose(FREQ_STEP_UP_IN) &&
      !FREQ_STEP_DOWN_IN |-> ##[1:4] STEP_VALID_OUT && !STEP_DOWN_OUT) else $error("no up");
   chk_step_down: assert property (up && DEVICE_RESET_N_IN && $rose(FREQ_STEP_DOWN_IN) &&
      !FREQ_STEP_UP_IN |-> ##[1:4] STEP_VALID_OUT && STEP_DOWN_OUT) else $error("no down");
endmodule // ckcp_properties

// ---- tb/ckcp_host.sv ----
// serial host model: clocks the serial pin only inside frames
`timescale 1ns/1ps
module ckcp_host (
   input  wire clk_in,
   input  wire frame_in,
   input  wire data_oe_in,
   input  wire data_in,
   output reg  sclk_out,
   output wire sda_out
);
   initial sclk_out = 1'b1;
   // idles high between frames so a stuck copy shows
   always @(posedge clk_in) sclk_out <= frame_in ? ~sclk_out : 1'b1;
   assign sda_out = data_oe_in ? data_in : 1'b1; // pulled-up line
endmodule // ckcp_host

// ---- tb/tb.sv ----
// self-checking bench for the clock generator control pins
`timescale 1ns/1ps
`include "ckcp_map.vh"
module tb;
   reg clk = 1'b0, nrst = 1'b0, i2c = 1'b1, four = 1'b0, cs_n = 1'b1, drv = 1'b0, dat = 1'b0;
   reg drst_n = 1'b1, odis = 1'b0, lock = 1'b0, xtal = 1'b1, iclr = 1'b0, ral_n = 1'b1;
   reg srst = 1'b0, dn = 1'b0, upp = 1'b0, man = 1'b1, frame = 1'b0;
   reg [1:0] ch = 2'h2;
   reg [7:0] rows [0:5] = '{8'hB4, 8'h98, 8'h1D, 8'h38, 8'h5B, 8'h78};
   integer n_fail = 0, checks = 0, i, k, cnt = 0;
   wire sd_o, sd_oe, a1_o, a1_oe, i2cm, csel, sco, lks, lsn, irqn, divr, sv, sdn, sclk, sda;
   wire cdo, dra;
   wire [1:0] alow, act;
   wire [3:0] stgt;
   wire [15:0] samt;
   wire [9:0] en;
   wire a1w = a1_oe ? a1_o : 1'b1; // board strap high when released
   always #20 clk = ~clk;
   ckcp_host u_ckcp_host (.clk_in(clk), .frame_in(frame), .data_oe_in(sd_oe), .data_in(sd_o),
      .sclk_out(sclk), .sda_out(sda));
   ckcp_pins u_ckcp_pins (.REF_CLK_IN(clk), .NRST_IN(nrst), .I2C_SELECT_IN(i2c),
      .SPI_FOUR_WIRE_IN(four), .SERIAL_CLK_IN(sclk), .SERIAL_DATA_IN(sda),
      .SERIAL_DATA_OUT(sd_o), .SERIAL_DATA_OE_OUT(sd_oe), .CORE_DATA_IN(dat),
      .CORE_DATA_DRIVE_IN(drv), .CORE_DATA_OUT(cdo), .ADDR_BIT1_OR_READ_DATA_IN(a1w),
      .ADDR_BIT1_OR_READ_DATA_OUT(a1_o), .ADDR_BIT1_OR_READ_DATA_OE_OUT(a1_oe),
      .ADDR_BIT0_OR_CHIP_SELECT_N_IN(cs_n), .I2C_MODE_OUT(i2cm), .I2C_ADDR_LOW_OUT(alow),
      .CHIP_SELECTED_OUT(csel), .SERIAL_CLK_OUT(sco), .DEVICE_RESET_N_IN(drst_n),
      .OUTPUT_DISABLE_IN(odis), .CLK_OUT_ENABLE_OUT(en), .PLL_LOCKED_IN(lock),
      .CRYSTAL_PRESENT_IN(xtal), .PLL_LOCK_STATUS_OUT(lks), .CRYSTAL_SIGNAL_LOSS_N_OUT(lsn),
      .IRQ_OUT_N_OUT(irqn), .IRQ_CLEAR_IN(iclr), .DIVIDER_REALIGN_N_IN(ral_n),
      .SOFT_RESET_IN(srst), .DIVIDER_RESET_OUT(divr), .FREQ_STEP_DOWN_IN(dn),
      .FREQ_STEP_UP_IN(upp), .STEP_OUTPUT_SEL_IN(4'h5), .STEP_SIZE_IN(16'h0123),
      .STEP_VALID_OUT(sv), .STEP_DOWN_OUT(sdn), .STEP_TARGET_OUT(stgt),
      .STEP_AMOUNT_OUT(samt), .MANUAL_PIN_MODE_IN(man), .INPUT_CHOICE_BIT0_IN(ch[0]),
      .INPUT_CHOICE_BIT1_IN(ch[1]), .ACTIVE_INPUT_OUT(act), .DEVICE_RESET_ACTIVE_OUT(dra));
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
         end
      end
   endtask
   task cyc(input integer n); repeat (n) @(negedge clk); endtask
   task tally_and_finish;
      begin
         if (n_fail == 0 && checks > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   // reset held four cycles, defaults looked at while it is held
   task rst_chk;
      begin
         nrst = 1'b0; cyc(2);
         chk({en, irqn, lks, act}, {10'h000, 2'h2, `CKCP_INPUT_SEL_RST});
         chk(samt, `CKCP_STEP_RST);
         chk(stgt, `CKCP_SEL_OUT_RST);
         cyc(2); nrst = 1'b1; cyc(4);
      end
   endtask
   // hang guard well beyond the run length
   always @(posedge clk) begin
      cnt = cnt + 1;
      if (cnt == 3000) begin
         n_fail = n_fail + 1;
         tally_and_finish;
      end
   end
   initial begin
      rst_chk;
      for (i = 0; i < 6; i = i + 1) begin
         {i2c, four, cs_n, drv, dat} = rows[i][7:3]; cyc(4);
         chk(i2cm, rows[i][7]);
         chk({sd_oe, a1_oe, csel}, rows[i][2:0]);
         chk(alow, rows[i][7] ? {1'b1, cs_n} : 2'h0);
         chk({sd_o, a1_o, cdo}, {~rows[i][7] & rows[i][3], rows[i][3],
             ~(rows[i][2] & (rows[i][7] | ~rows[i][3]))});
      end
      // serial clock copy must follow the host clock inside a frame
      frame = 1'b1;
      k = 0;
      repeat (6) begin
         cyc(1);
         if (sco === 1'b0) k = k + 1;
      end
      chk(k, 2);
      frame = 1'b0; cyc(4); chk(sco, 1'b1);
      iclr = 1'b1; cyc(1); iclr = 1'b0; cyc(1); chk(irqn, 1'b1);
      lock = 1'b1; cyc(4); chk({lks, irqn}, 2'h2);
      iclr = 1'b1; cyc(1); iclr = 1'b0; cyc(2); chk(irqn, 1'b1);
      xtal = 1'b0; cyc(4); chk({lsn, irqn}, 2'h0);
      // a change in a clear cycle must still pull the line low
      iclr = 1'b1; lock = 1'b0; cyc(3); chk(irqn, 1'b0);
      cyc(1); chk(irqn, 1'b1); iclr = 1'b0;
      odis = 1'b1; cyc(4); chk(en, 16'h0000);
      odis = 1'b0; cyc(4); chk(en, 16'h03FF);
      chk(divr, 1'b0); ral_n = 1'b0; cyc(4); chk(divr, 1'b1);
      ral_n = 1'b1; srst = 1'b1; cyc(4); chk(divr, 1'b1);
      srst = 1'b0; cyc(4); chk(divr, 1'b0);
      for (i = 0; i < 3; i = i + 1) begin
         dn = (i != 0); upp = (i != 1); k = 0;
         repeat (6) begin
            @(posedge clk);
            #1;
            if (sv === 1'b1 && (sdn === i[0] || i == 2)) k = k + 1;
         end
         chk(k, (i < 2) ? 16'h0001 : 16'h0000);
         if (i < 2) chk({stgt, samt}, 20'h50123);
         cyc(1); dn = 1'b0; upp = 1'b0; cyc(3);
      end
      ch = 2'h1; cyc(4); chk(act, 2'h1);
      man = 1'b0; ch = 2'h2; cyc(4); chk(act, 2'h1);
      drst_n = 1'b0; cyc(4); chk({en, act, dra}, {10'h000, 2'h3, 1'b1});
      chk({sdn, stgt, samt}, {1'b0, `CKCP_SEL_OUT_RST, `CKCP_STEP_RST});
      upp = 1'b1; cyc(3); chk(sv, 1'b0);
      cyc(1); upp = 1'b0;
      drst_n = 1'b1; cyc(4); chk(dra, 1'b0);
      rst_chk;
      tally_and_finish;
   end
endmodule // tb
bind ckcp_pins ckcp_properties #(.NUM_OUT(NUM_OUT)) u_ckcp_properties (.*);
